// file: hdl/agcdd_timing.sv
// Left-channel gain-loop decay and debounce timing registers with their interval counters.
`include "agcdd_defs.svh"
// How it works
// - Decay base is (2N+1) times 512 samples.
// - Three-bit field multiplies decay by power-of-two.
// - Noise debounce codes: zero none, 4..2048 samples.
// - Upper noise codes use multiples of 4096.
// - Signal debounce codes: zero none, 4..2048 samples.
// - Top signal codes use 2x..6x of 2048.
// - All timing fields reset to zero.
// - Loop idles while enable is low.
// - Zero noise threshold disables noise detection.
module agcdd_timing
  import agcdd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample_tick,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic loop_enable,
  input wire logic [4:0] noise_threshold,
  input wire logic noise_cond,
  input wire logic signal_cond,
  output agcdd_len_t decay_len,
  output logic decay_step,
  output logic noise_established,
  output logic signal_established
);
  agcdd_bank_s st; // Registered state.
  agcdd_bank_s next_st; // Next state.
  agcdd_len_t noise_len; // Noise debounce period in samples.
  agcdd_len_t signal_len; // Signal debounce period in samples.
  logic noise_gated; // Noise condition after the threshold gate.

  // Decay period: odd multiple of the 512-sample base, then shifted by the multiplier code.
  // The odd factor is widened before the shift so the top base codes cannot lose bits.
  function automatic agcdd_len_t decay_of(input logic [7:0] r);
    agcdd_len_t base;
    base = agcdd_len_t'({r[`AGCDD_DECAY_BASE_MSB:`AGCDD_DECAY_BASE_LSB], 1'b1}) << `AGCDD_DECAY_UNIT_SHIFT;
    decay_of = base << r[`AGCDD_DECAY_MULT_MSB:`AGCDD_DECAY_MULT_LSB];
  endfunction : decay_of

  // Noise debounce decode; the printed list repeats codes, so the doubling ladder is assumed.
  function automatic agcdd_len_t noise_of(input logic [4:0] c);
    logic [4:0] m;
    m = 5'h00;
    if (c == 5'h00) begin
      noise_of = '0;
    end else if (c <= 5'h0a) begin
      noise_of = `AGCDD_DEB_STEP << (c - 5'h01);
    end else begin
      m = c - 5'h0a;
      // Saturate so the all-ones code lands on twenty units.
      if (m > `AGCDD_NOISE_MAX_MULT) begin
        m = `AGCDD_NOISE_MAX_MULT;
      end
      noise_of = 24'(`AGCDD_NOISE_UNIT * m);
    end
  endfunction : noise_of

  // Signal debounce decode; codes above ten step in 2048-sample units.
  // The top code lands on six units; the codes in between are a best reading of an uneven list.
  function automatic agcdd_len_t signal_of(input logic [3:0] c);
    if (c == 4'h0) begin
      signal_of = '0;
    end else if (c <= 4'ha) begin
      signal_of = `AGCDD_DEB_STEP << (c - 4'h1);
    end else begin
      signal_of = 24'(`AGCDD_SIGNAL_UNIT * (c - 4'h9));
    end
  endfunction : signal_of

  assign noise_len = noise_of(st.noise_code);
  assign signal_len = signal_of(st.signal_code);
  assign decay_len = decay_of(st.decay_reg);
  // A zero threshold code turns silence detection off entirely.
  assign noise_gated = noise_cond && (noise_threshold != 5'h00);

  // Register access, read data and the decay interval timer.
  always_comb begin
    next_st = st;
    next_st.decay_step = 1'b0;
    // Only page zero carries this bank; other pages are ignored.
    if (reg_wr && reg_page == `AGCDD_PAGE_MAIN) begin
      case (reg_addr)
        `AGCDD_OFS_DECAY: next_st.decay_reg = reg_wdata;
        // Reserved bits are not stored, so they keep reading zero whatever is written.
        `AGCDD_OFS_NOISE: next_st.noise_code = reg_wdata[`AGCDD_NOISE_MSB:0];
        `AGCDD_OFS_SIGNAL: next_st.signal_code = reg_wdata[`AGCDD_SIGNAL_MSB:0];
        default: next_st.noise_code = st.noise_code;
      endcase
    end
    if (reg_rd) begin
      // Unmapped addresses and other pages read as zero.
      next_st.rdata = 8'h00;
      if (reg_page == `AGCDD_PAGE_MAIN) begin
        case (reg_addr)
          `AGCDD_OFS_DECAY: next_st.rdata = st.decay_reg;
          `AGCDD_OFS_NOISE: next_st.rdata = {3'b000, st.noise_code};
          `AGCDD_OFS_SIGNAL: next_st.rdata = {4'b0000, st.signal_code};
          default: next_st.rdata = 8'h00;
        endcase
      end
    end
    case (st.state)
      AGCDD_IDLE: begin
        next_st.decay_cnt = '0;
        if (loop_enable) begin
          next_st.state = AGCDD_RUN;
        end
      end
      AGCDD_RUN: begin
        if (!loop_enable) begin
          next_st.state = AGCDD_IDLE;
          next_st.decay_cnt = '0;
        end else if (sample_tick) begin
          // The >= compare stops a shortened period from wrapping the counter.
          if (st.decay_cnt + 24'h00_0001 >= decay_len) begin
            next_st.decay_cnt = '0;
            next_st.decay_step = 1'b1;
          end else begin
            next_st.decay_cnt = st.decay_cnt + 24'h00_0001;
          end
        end
      end
      default: begin
        next_st.state = AGCDD_IDLE;
        next_st.decay_cnt = '0;
      end
    endcase
  end

  // Synchronous active-low reset clears every field except the state, which loads AGCDD_IDLE.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st.decay_reg <= `AGCDD_RST_DECAY;
      st.noise_code <= `AGCDD_RST_CODE;
      st.signal_code <= 4'h0;
      st.rdata <= 8'h00;
      st.state <= AGCDD_IDLE;
      st.decay_cnt <= '0;
      st.decay_step <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign decay_step = st.decay_step;

  // Noise persistence counter; gated by the loop enable and the threshold.
  agcdd_debounce u_noise (
    .clk(clk),
    .rstn(rstn),
    .tick(sample_tick),
    .enable(loop_enable),
    .cond(noise_gated),
    .len(noise_len),
    .est(noise_established)
  );

  // Signal persistence counter.
  agcdd_debounce u_signal (
    .clk(clk),
    .rstn(rstn),
    .tick(sample_tick),
    .enable(loop_enable),
    .cond(signal_cond),
    .len(signal_len),
    .est(signal_established)
  );

  // Every check below lives in the one clock domain, so clock and reset are given once here.
  // Checks are off while reset is low; the first edge after release is checked separately.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_reset_zero: assert property ($rose(rstn) |-> decay_len == 24'h00_0200 && noise_len == '0
    && signal_len == '0 && reg_rdata == 8'h00 && !decay_step) else $error("timing fields not zero after reset");
  a_decay_base: assert property (st.decay_reg == 8'hf8 |-> decay_len == 24'h00_7e00)
    else $error("decay base code 31 not 63 units");
  a_decay_mult: assert property (st.decay_reg == 8'h07 |-> decay_len == 24'h01_0000)
    else $error("multiplier 128 not applied");
  a_noise_low: assert property ((st.noise_code == 5'h01 |-> noise_len == 24'h00_0004)
    and (st.noise_code == 5'h0a |-> noise_len == 24'h00_0800)) else $error("noise low codes wrong");
  a_noise_high: assert property ((st.noise_code == 5'h0e |-> noise_len == 24'h00_4000)
    and (st.noise_code == 5'h1f |-> noise_len == 24'h01_4000)) else $error("noise high codes wrong");
  a_signal_low: assert property ((st.signal_code == 4'h3 |-> signal_len == 24'h00_0010)
    and (st.signal_code == 4'h8 |-> signal_len == 24'h00_0200)) else $error("signal low codes wrong");
  a_signal_high: assert property (st.signal_code == 4'hf |-> signal_len == 24'h00_3000)
    else $error("signal top code not six units");
  a_reserved_read: assert property (reg_rd && reg_addr == `AGCDD_OFS_NOISE |=> reg_rdata[7:5] == 3'b000)
    else $error("reserved noise bits read nonzero");
  a_loop_idle: assert property (!loop_enable |=> !decay_step && !noise_established && !signal_established
    ##1 !decay_step) else $error("loop active while disabled");
  // Dropping the enable parks the decay timer at zero so a re-enable starts a full period.
  a_decay_park: assert property (!loop_enable |=> st.decay_cnt == '0)
    else $error("decay count kept while disabled");
  // A noise write lands in the next cycle with the reserved bits dropped.
  a_noise_write: assert property (reg_wr && reg_page == `AGCDD_PAGE_MAIN && reg_addr == `AGCDD_OFS_NOISE
    |=> {3'b000, st.noise_code} == ($past(reg_wdata) & 8'h1f)) else $error("noise code write lost");
  // The shortest decay is 512 ticks, so two steps in a row mean the counter misfired.
  a_step_single: assert property (decay_step |=> !decay_step)
    else $error("decay step repeated back to back");
  a_noise_gate: assert property (noise_threshold == 5'h00 |=> !noise_established)
    else $error("noise detected with zero threshold");
  a_decay_period: assert property (decay_step |-> $past(st.decay_cnt) + 24'h00_0001 >= $past(decay_len))
    else $error("decay step before full period");

  c_decay_step: cover property (decay_step);
  c_noise_est: cover property (noise_established && noise_threshold != 5'h00);
  c_signal_est: cover property ($rose(signal_established));
  // The saturating top noise code is the one most likely to be decoded wrongly.
  c_noise_top: cover property (st.noise_code == 5'h1f);
  // A write to a foreign page must be seen and ignored.
  c_foreign_write: cover property (reg_wr && reg_page != `AGCDD_PAGE_MAIN);
endmodule : agcdd_timing

// file: inc/agcdd_defs.svh
// Offsets, field positions, reset values and timing counts of the gain-loop timing bank.
`ifndef AGCDD_DEFS_SVH
`define AGCDD_DEFS_SVH
`define AGCDD_PAGE_MAIN 8'h00
`define AGCDD_OFS_DECAY 8'h5a
`define AGCDD_OFS_NOISE 8'h5b
`define AGCDD_OFS_SIGNAL 8'h5c
`define AGCDD_DECAY_BASE_MSB 7
`define AGCDD_DECAY_BASE_LSB 3
`define AGCDD_DECAY_MULT_MSB 2
`define AGCDD_DECAY_MULT_LSB 0
`define AGCDD_NOISE_MSB 4
`define AGCDD_SIGNAL_MSB 3
`define AGCDD_RST_DECAY 8'h00
`define AGCDD_RST_CODE 5'h00
`define AGCDD_DECAY_UNIT_SHIFT 9
`define AGCDD_DEB_STEP 24'h00_0004
`define AGCDD_NOISE_UNIT 24'h00_1000
`define AGCDD_SIGNAL_UNIT 24'h00_0800
`define AGCDD_NOISE_MAX_MULT 5'h14
`endif

// file: inc/agcdd_pkg.sv
// Types shared by the gain-loop timing bank and its debounce counter.
package agcdd_pkg;
  // Interval lengths count sample periods; the longest decay needs 22 bits.
  typedef logic [23:0] agcdd_len_t;
  // Decay timer states, one-hot.
  typedef enum logic [1:0] {
    AGCDD_IDLE = 2'b01,
    AGCDD_RUN = 2'b10
  } agcdd_state_e;
  // State of one debounce counter.
  typedef struct packed {
    agcdd_len_t cnt;
    logic est;
  } agcdd_deb_s;
  // State of the timing bank.
  typedef struct packed {
    logic [7:0] decay_reg;
    logic [4:0] noise_code;
    logic [3:0] signal_code;
    logic [7:0] rdata;
    agcdd_state_e state;
    agcdd_len_t decay_cnt;
    logic decay_step;
  } agcdd_bank_s;
endpackage : agcdd_pkg

// file: hdl/agcdd_debounce.sv
// Persistence counter that declares a condition established after a programmed run of sample periods.
`include "agcdd_defs.svh"
module agcdd_debounce
  import agcdd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic enable,
  input wire logic cond,
  input wire agcdd_len_t len,
  output logic est
);
  agcdd_deb_s st; // Registered state.
  agcdd_deb_s next_st; // Next state.

  // Count sample ticks while the condition holds; any lapse restarts the count.
  always_comb begin
    next_st = st;
    if (!enable || !cond) begin
      next_st.cnt = '0;
      next_st.est = 1'b0;
    end else if (len == '0) begin
      next_st.est = 1'b1; // A zero period means no debounce at all.
    end else if (tick && !st.est) begin
      next_st.cnt = st.cnt + 24'h00_0001;
      // Compare with >= so a shortened period mid-count cannot be skipped.
      if (st.cnt + 24'h00_0001 >= len) begin
        next_st.est = 1'b1;
      end
    end
  end

  // Synchronous active-low reset.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign est = st.est;

  a_lapse_clears: assert property (@(posedge clk) disable iff (!rstn)
    (enable && !cond) |=> !est) else $error("debounce held after condition lapsed");
  a_needs_full_run: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(est) && $past(len) != '0) |-> $past(st.cnt) + 24'h00_0001 >= $past(len))
    else $error("debounce established before full count");
endmodule : agcdd_debounce

// file: bench/agcdd_host.sv
// Host model that drives the paged register port one byte at a time.
module agcdd_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_page,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port idles with both strobes low.
  initial begin
    {reg_page, reg_addr, reg_wdata} = 24'h00_0000;
    {reg_wr, reg_rd} = 2'b00;
  end
  // Writes one byte; reserved bits are sent as zero so their reset value is kept.
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_page = pg;
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = (a == 8'h5b) ? (d & 8'h1f) : (a == 8'h5c) ? (d & 8'h0f) : d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    // Released lines flip so a stale value is never mistaken for live data.
    reg_wdata = ~reg_wdata;
  endtask : wr
  // Reads one byte; the answer is registered, so it is taken one edge later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_page = 8'h00;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    d = reg_rdata;
  endtask : rd
endmodule : agcdd_host

// file: bench/agcdd_timing_tb.sv
// Self-checking bench for the gain-loop timing bank.
module agcdd_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import agcdd_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, en = 1'b0, ncond = 1'b0, scond = 1'b0;
  logic [4:0] thr = 5'h00;
  logic [7:0] page, addr, wdata, rdata, d;
  logic wr, rd, step, nest, sest;
  agcdd_len_t dlen;
  int bad_count = 0, n_tests = 0, nt = 0, ck = 0, base = 0, t = 0;
  // Clock of 8 ns.
  always #4 clk = ~clk;
  // Sample tick on every other edge; its phase equals ck[0] just after an edge.
  always @(posedge clk) begin
    ck <= ck + 1;
    if (tick) nt <= nt + 1;
    #1 tick = ~tick;
  end
  agcdd_timing agcdd_timing_inst (.clk(clk), .rstn(rstn), .sample_tick(tick), .reg_page(page),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .loop_enable(en), .noise_threshold(thr), .noise_cond(ncond), .signal_cond(scond),
    .decay_len(dlen), .decay_step(step), .noise_established(nest), .signal_established(sest));
  agcdd_host agcdd_host_inst (.clk(clk), .reg_rdata(rdata), .reg_page(page), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // Compares a value of up to 24 bits; case equality keeps unknowns from matching.
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Lands just after an edge whose following edge carries no tick, then restarts the tick count.
  task automatic align();
    @(posedge clk) #1;
    if (ck[0]) @(posedge clk) #1;
    base = nt;
  endtask : align
  // Bounded wait for a flag (0 signal, 1 noise, 2 decay step); gives ticks seen since align.
  task automatic wt(input int w);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk) #1;
      if ((w == 0 ? sest : w == 1 ? nest : step) === 1'b1) begin
        t = nt - base;
        return;
      end
    end
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask : wt
  // Reset values of the three registers and the decay length.
  task automatic t_reset();
    for (int a = 8'h5a; a <= 8'h5c; a++) begin
      agcdd_host_inst.rd(8'(a), d);
      chk(d, 8'h00);
    end
    chk(dlen, 24'h00_0200);
  endtask : t_reset
  // Decay codes, readback, foreign page and unmapped offset.
  task automatic t_regs();
    logic [7:0] c[6] = '{8'h00, 8'h0f, 8'hfa, 8'hf8, 8'h07, 8'h0b};
    logic [23:0] e[6] = '{24'h00_0200, 24'h03_0000, 24'h01_f800, 24'h00_7e00, 24'h01_0000, 24'h00_3000};
    logic [7:0] n[4] = '{8'h0a, 8'h0e, 8'h03, 8'h08};
    for (int i = 0; i < 6; i++) begin
      agcdd_host_inst.wr(8'h00, 8'h5a, c[i]);
      agcdd_host_inst.rd(8'h5a, d);
      chk(d, c[i]);
      chk(dlen, e[i]);
    end
    agcdd_host_inst.wr(8'h01, 8'h5a, 8'h00);
    agcdd_host_inst.rd(8'h5a, d);
    chk(d, 8'h0b);
    agcdd_host_inst.rd(8'h5d, d);
    chk(d, 8'h00);
    agcdd_host_inst.wr(8'h00, 8'h5b, 8'h1f);
    agcdd_host_inst.rd(8'h5b, d);
    chk(d, 8'h1f);
    agcdd_host_inst.wr(8'h00, 8'h5c, 8'h0f);
    agcdd_host_inst.rd(8'h5c, d);
    chk(d, 8'h0f);
    // Middle noise and signal codes, so the design's length checks see them too.
    for (int i = 0; i < 4; i++) begin
      agcdd_host_inst.wr(8'h00, (i < 2) ? 8'h5b : 8'h5c, n[i]);
      agcdd_host_inst.rd((i < 2) ? 8'h5b : 8'h5c, d);
      chk(d, n[i]);
    end
  endtask : t_regs
  // Code 1 debounces over 4 ticks, a lapse restarts, a zero threshold and a low enable block.
  task automatic t_deb();
    agcdd_host_inst.wr(8'h00, 8'h5b, 8'h01);
    agcdd_host_inst.wr(8'h00, 8'h5c, 8'h01);
    thr = 5'h01;
    en = 1'b1;
    align();
    scond = 1'b1;
    wt(0);
    chk(t, 4);
    ncond = 1'b1;
    repeat (4) @(posedge clk);
    #1 ncond = 1'b0;
    chk(nest, 1'b0);
    align();
    ncond = 1'b1;
    wt(1);
    chk(t, 4);
    thr = 5'h00;
    repeat (12) @(posedge clk);
    #1 chk(nest, 1'b0);
    en = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(sest, 1'b0);
    {scond, ncond} = 2'b00;
  endtask : t_deb
  // Decay code 0 steps after 512 ticks once the loop is enabled.
  task automatic t_decay();
    agcdd_host_inst.wr(8'h00, 8'h5a, 8'h00);
    align();
    en = 1'b1;
    wt(2);
    chk(t, 512);
    en = 1'b0;
  endtask : t_decay
  // Main sequence: reset for 10 cycles, then the scenarios.
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset();
    t_regs();
    t_deb();
    t_decay();
    // A second reset in mid-run must clear the nonzero codes left by the scenarios.
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset();
    give_verdict();
  end
endmodule : agcdd_timing_tb
